//--- hdl/special_bank_device.sv
// Special register bank of the UART bridge, device end
// Function
// RULE1 - Baud tick divides by documented prescaler product
// RULE2 - Prescale holds M high, N low, resets 10
// RULE3 - Software should program M to 1 or 2
// RULE4 - Control bits 7:4 hold sample clock value
// RULE5 - Special registers need key and access bit
// RULE6 - Special function needs both keys; resets zero
// RULE7 - Offset 05 selects FIFO or error count
// RULE8 - Read-only receive FIFO byte count
// RULE9 - Read-only count of errored receive bytes
// RULE10 - Read-only transmit FIFO byte count at 06
// RULE11 - Bit 4 enables burst register access
// RULE12 - Bit 3 loops receive path to transmit
// RULE13 - Bit 1 enables automatic DSR/DTR flow
// RULE14 - Bit 0 forces continuous transmission
// RULE15 - Transmit idle time register at 08
// RULE16 - Control bits enable Xon, empty, timeout, idle
// RULE17 - Control register resets to 06
// RULE18 - Status bits 7..1 flag interrupt sources
// RULE19 - Writing status bit 0 clears all flags
// RULE20 - Offset 0F shares extra features and status
// RULE21 - Host unlocks by writing 5A under key
// RULE22 - Counters follow every push and pop
// RULE23 - Counter writes ignored; reserved bits zero
`include "uart_bank_cfg.svh"

module special_bank_device (
	input  wire logic        clk,
	input  wire logic        srst,
	uart_bank_if.dev         bus,
	input  wire logic        modem_bit7,
	input  wire logic [15:0] baud_divisor,
	input  wire logic        rx_push,
	input  wire logic        rx_push_err,
	input  wire logic        rx_pop,
	input  wire logic        rx_pop_err,
	input  wire logic        tx_push,
	input  wire logic        tx_pop,
	input  wire logic [6:0]  int_events,
	output logic             baud_tick,
	output logic [3:0]       prescale_m,
	output logic [3:0]       prescale_n,
	output logic [3:0]       sample_clock_value,
	output logic             loopback_en,
	output logic             burst_en,
	output logic             auto_dsr_dtr_en,
	output logic             force_tx,
	output logic [7:0]       tx_idle_time,
	output logic [3:0]       txrx_enables,
	output logic [7:0]       extra_features
);

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [7:0]  line_control_r;           // Key holder at 03
	logic [7:0]  clock_prescale_r;         // M and N
	logic [7:0]  special_function_ctrl_r;  // Feature switches
	logic [7:0]  special_unlock_r;         // Second key
	logic [7:0]  tx_idle_time_r;           // Idle gap length
	logic [7:0]  txrx_control_r;           // Sample value and enables
	logic [7:0]  extra_features_r;         // Shares offset 0F
	logic [7:0]  int_status_r;             // Sticky flags 7:1
	logic [7:0]  rx_fifo_count_r;          // Bytes in receive FIFO
	logic [7:0]  rx_error_count_r;         // Errored bytes in it
	logic [7:0]  tx_fifo_count_r;          // Bytes in transmit FIFO
	logic [3:0]  last_addr_r;              // Address of previous beat
	logic        ack_r;                    // Answer strobe
	logic [7:0]  rdata_r;                  // Answer data
	logic [39:0] baud_cnt_r;               // Baud divider counter
	logic        baud_tick_r;              // Baud tick

	// ------------------------------------------------------------------
	// Address and access decode
	// ------------------------------------------------------------------
	// Burst beats take the next offset only while bursts are enabled
	wire [3:0] eff_addr = (bus.burst
		&& special_function_ctrl_r[`SFC_BURST])
		? last_addr_r + 4'h1 : bus.addr;              // see RULE11
	wire key_ok = (line_control_r == `KEY_LINE_CONTROL);
	wire sfc_ok = key_ok
		&& (special_unlock_r == `KEY_SPECIAL_UNLOCK); // see RULE6
	wire spc_ok = key_ok
		&& special_function_ctrl_r[`SFC_SPECIAL_ACCESS]; // see RULE5
	wire wr     = bus.req && bus.we;
	wire wr_lcr = wr && (eff_addr == `OFS_LINE_CONTROL);
	wire wr_cpr = wr && spc_ok && (eff_addr == `OFS_CLOCK_PRESCALE);
	wire wr_sfc = wr && sfc_ok && (eff_addr == `OFS_SPECIAL_FUNC);
	wire wr_unl = wr && key_ok && (eff_addr == `OFS_SPECIAL_UNLOCK);
	wire wr_tit = wr && spc_ok && (eff_addr == `OFS_TX_IDLE_TIME);
	wire wr_trc = wr && spc_ok && (eff_addr == `OFS_TXRX_CONTROL);
	// Offset 0F: status when access bit set, extra features otherwise
	wire at_0f  = (eff_addr == `OFS_INT_STATUS);
	wire wr_isc = wr && at_0f && spc_ok;                // see RULE20
	wire wr_efc = wr && at_0f
		&& !special_function_ctrl_r[`SFC_SPECIAL_ACCESS]; // see RULE20
	wire clr_flags = wr_isc && bus.wdata[`ISC_CLEAR_BIT]; // see RULE19

	// ------------------------------------------------------------------
	// Read multiplexer
	// ------------------------------------------------------------------
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;                   // Gated or unmapped reads zero
		case (eff_addr)
			`OFS_LINE_CONTROL:   rd_mux = line_control_r;
			`OFS_CLOCK_PRESCALE: rd_mux = spc_ok ? clock_prescale_r : 8'h00;
			`OFS_RX_COUNT: begin
				if (spc_ok) begin
					// Counter select bit picks the errored count
					rd_mux = special_function_ctrl_r[`SFC_COUNT_SELECT]
						? rx_error_count_r : rx_fifo_count_r; // see RULE7
				end
			end
			`OFS_TX_FIFO_COUNT:  rd_mux = spc_ok ? tx_fifo_count_r : 8'h00;
			`OFS_SPECIAL_FUNC:   rd_mux = sfc_ok ? special_function_ctrl_r
				: 8'h00;
			`OFS_TX_IDLE_TIME:   rd_mux = spc_ok ? tx_idle_time_r : 8'h00;
			`OFS_TXRX_CONTROL:   rd_mux = spc_ok ? txrx_control_r : 8'h00;
			`OFS_SPECIAL_UNLOCK: rd_mux = key_ok ? special_unlock_r : 8'h00;
			`OFS_INT_STATUS: begin
				if (!special_function_ctrl_r[`SFC_SPECIAL_ACCESS]) begin
					rd_mux = extra_features_r;
				end else if (key_ok) begin
					rd_mux = int_status_r;
				end
			end
			default:             rd_mux = 8'h00;
		endcase
	end

	// ------------------------------------------------------------------
	// Bus answer: one cycle after every request
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			ack_r       <= 1'b0;
			rdata_r     <= 8'h00;
			last_addr_r <= 4'h0;
		end else begin
			ack_r <= bus.req;
			if (bus.req) begin
				rdata_r     <= bus.we ? 8'h00 : rd_mux;
				last_addr_r <= eff_addr;
			end
		end
	end

	// ------------------------------------------------------------------
	// Writable registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			line_control_r          <= `RST_LINE_CONTROL;
			clock_prescale_r        <= `RST_CLOCK_PRESCALE;  // see RULE2
			special_function_ctrl_r <= `RST_SPECIAL_FUNC;    // see RULE6
			special_unlock_r        <= `RST_SPECIAL_UNLOCK;
			tx_idle_time_r          <= `RST_TX_IDLE_TIME;    // see RULE15
			txrx_control_r          <= `RST_TXRX_CONTROL;    // see RULE17
			extra_features_r        <= `RST_EXTRA_FEATURES;
		end else begin
			if (wr_lcr) line_control_r <= bus.wdata;
			if (wr_cpr) clock_prescale_r <= bus.wdata;       // see RULE2
			if (wr_sfc) special_function_ctrl_r <= bus.wdata;
			if (wr_unl) special_unlock_r <= bus.wdata;
			if (wr_tit) tx_idle_time_r <= bus.wdata;         // see RULE15
			if (wr_trc) txrx_control_r <= bus.wdata;         // see RULE4
			// Reserved bits of extra features stay zero
			if (wr_efc) extra_features_r <= bus.wdata
				& `EXTRA_FEATURES_MASK;                      // see RULE23
		end
	end

	// ------------------------------------------------------------------
	// Interrupt status: events win over a same-cycle clear
	// ------------------------------------------------------------------
	logic [7:0] int_status_nxt;
	always_comb begin
		int_status_nxt = int_status_r;
		if (clr_flags) begin
			int_status_nxt = 8'h00;                          // see RULE19
		end else if (wr_isc) begin
			int_status_nxt = {bus.wdata[7:1], 1'b0};
		end
		// Clear bit never reads back as one
		int_status_nxt = int_status_nxt | {int_events, 1'b0}; // see RULE18
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			int_status_r <= `RST_INT_STATUS;
		end else begin
			int_status_r <= int_status_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Occupancy counters; bus writes never reach them
	// ------------------------------------------------------------------
	function automatic logic [7:0] step(input logic [7:0] cnt,
		input logic up, input logic down);
		// Push and pop together leave the count alone
		step = cnt + {7'h00, up} - {7'h00, down};
	endfunction

	always_ff @(posedge clk) begin
		if (srst) begin
			rx_fifo_count_r  <= `RST_COUNT;                  // see RULE8
			rx_error_count_r <= `RST_COUNT;                  // see RULE9
			tx_fifo_count_r  <= `RST_COUNT;                  // see RULE10
		end else begin
			rx_fifo_count_r  <= step(rx_fifo_count_r, rx_push,
				rx_pop);                                     // see RULE22
			rx_error_count_r <= step(rx_error_count_r,
				rx_push && rx_push_err, rx_pop && rx_pop_err); // see RULE9
			tx_fifo_count_r  <= step(tx_fifo_count_r, tx_push,
				tx_pop);                                     // see RULE22
		end
	end

	// ------------------------------------------------------------------
	// Baud generator
	// ------------------------------------------------------------------
	// Period = DL * (16 - sample + N) * 2^(M + 2*mcr7 - 1); the minus one
	// is taken as a final halving so M = 0 still works
	wire [4:0]  sample_span = 5'h10 - {1'b0, txrx_control_r[7:4]}
		+ {1'b0, clock_prescale_r[3:0]};
	wire [4:0]  shift_exp = {1'b0, clock_prescale_r[7:4]}
		+ {2'b00, modem_bit7, 1'b0};
	wire [20:0] base_prod = baud_divisor * sample_span;
	wire [39:0] shifted = {19'h00000, base_prod} << shift_exp;
	wire [39:0] baud_period = shifted >> 1;                  // see RULE1
	wire        baud_wrap = (baud_cnt_r >= baud_period - 40'h1);

	always_ff @(posedge clk) begin
		if (srst) begin
			baud_cnt_r  <= 40'h0;
			baud_tick_r <= 1'b0;
		end else if (baud_period == 40'h0) begin
			// A zero divisor stops the generator
			baud_cnt_r  <= 40'h0;
			baud_tick_r <= 1'b0;
		end else begin
			baud_cnt_r  <= baud_wrap ? 40'h0 : baud_cnt_r + 40'h1;
			baud_tick_r <= baud_wrap;                        // see RULE1
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign bus.ack            = ack_r;
	assign bus.rdata          = rdata_r;
	assign baud_tick          = baud_tick_r;
	assign prescale_m         = clock_prescale_r[7:4];
	assign prescale_n         = clock_prescale_r[3:0];
	assign sample_clock_value = txrx_control_r[7:4];          // see RULE4
	assign loopback_en        =
		special_function_ctrl_r[`SFC_LOOPBACK];              // see RULE12
	assign burst_en           = special_function_ctrl_r[`SFC_BURST];
	assign auto_dsr_dtr_en    =
		special_function_ctrl_r[`SFC_AUTO_DSR_DTR];          // see RULE13
	assign force_tx           =
		special_function_ctrl_r[`SFC_FORCE_TX];              // see RULE14
	assign tx_idle_time       = tx_idle_time_r;
	assign txrx_enables       = txrx_control_r[3:0];          // see RULE16
	assign extra_features     = extra_features_r;

endmodule // special_bank_device

//--- shared/uart_bank_cfg.svh
// Offsets, field positions, reset values and keys of the special bank
`ifndef UART_BANK_CFG_SVH
`define UART_BANK_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_LINE_CONTROL     4'h3
`define OFS_CLOCK_PRESCALE   4'h4
`define OFS_RX_COUNT         4'h5
`define OFS_TX_FIFO_COUNT    4'h6
`define OFS_SPECIAL_FUNC     4'h7
`define OFS_TX_IDLE_TIME     4'h8
`define OFS_TXRX_CONTROL     4'h9
`define OFS_SPECIAL_UNLOCK   4'hD
`define OFS_INT_STATUS       4'hF

// ----------------------------------------------------------------------
// Keys and reset values
// ----------------------------------------------------------------------
`define KEY_LINE_CONTROL     8'hBF
`define KEY_SPECIAL_UNLOCK   8'h5A
`define RST_LINE_CONTROL     8'h00
`define RST_CLOCK_PRESCALE   8'h10
`define RST_SPECIAL_FUNC     8'h00
`define RST_TX_IDLE_TIME     8'h00
`define RST_TXRX_CONTROL     8'h06
`define RST_SPECIAL_UNLOCK   8'h00
`define RST_EXTRA_FEATURES   8'h00
`define RST_INT_STATUS       8'h00
`define RST_COUNT            8'h00

// ----------------------------------------------------------------------
// Special function control bits
// ----------------------------------------------------------------------
`define SFC_FORCE_TX         0
`define SFC_AUTO_DSR_DTR     1
`define SFC_SPECIAL_ACCESS   2
`define SFC_LOOPBACK         3
`define SFC_BURST            4
`define SFC_COUNT_SELECT     6

// Interrupt status clear bit, and writable mask of the extra features bits
`define ISC_CLEAR_BIT        0
`define EXTRA_FEATURES_MASK  8'hB7

`endif

//--- shared/uart_bank_pkg.sv
// Types shared by both ends of the special register bank
package uart_bank_pkg;

	// Host sequencer states
	typedef enum logic [1:0] {
		H_IDLE   = 2'b00,
		H_ISSUE  = 2'b01,
		H_WAIT   = 2'b10,
		H_UNLOCK = 2'b11
	} host_state_type;

	// Register word
	typedef logic [7:0] reg_byte_type;

endpackage

//--- shared/uart_bank_if.sv
// Register access link between host controller and register bank
interface uart_bank_if;
	logic                       req;    // One-cycle access request
	logic                       we;     // Write when high
	logic                       burst;  // Beat continues previous address
	logic [3:0]                 addr;   // Register offset
	uart_bank_pkg::reg_byte_type wdata; // Write data
	logic                       ack;    // One-cycle answer
	uart_bank_pkg::reg_byte_type rdata; // Read data, valid with ack

	modport dev  (input req, we, burst, addr, wdata, output ack, rdata);
	modport host (output req, we, burst, addr, wdata, input ack, rdata);
endinterface

//--- hdl/special_bank_host.sv
// Host controller end of the special register bank link
`include "uart_bank_cfg.svh"

module special_bank_host (
	input  wire logic        clk,
	input  wire logic        srst,
	uart_bank_if.host        bus,
	input  wire logic        cmd_valid,
	input  wire logic        cmd_write,
	input  wire logic        cmd_burst,
	input  wire logic        cmd_unlock,
	input  wire logic [3:0]  cmd_addr,
	input  wire logic [7:0]  cmd_wdata,
	output logic             cmd_ready,
	output logic             resp_valid,
	output logic [7:0]       resp_rdata
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	uart_bank_pkg::host_state_type state_r;  // Sequencer state
	logic       unlock_step_r;               // 0: key write, 1: unlock write
	logic       in_unlock_r;                 // Access is part of an unlock
	logic       req_r;                       // Request strobe
	logic       we_r;                        // Write flag
	logic       burst_r;                     // Burst beat flag
	logic [3:0] addr_r;                      // Offset
	logic [7:0] wdata_r;                     // Write data
	logic       ready_r;                     // Command accepted when high
	logic       resp_valid_r;                // Answer strobe
	logic [7:0] resp_rdata_r;                // Answer data

	// ------------------------------------------------------------------
	// Sequencer: one access in flight; unlock writes key then 5A
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r       <= uart_bank_pkg::H_IDLE;
			unlock_step_r <= 1'b0;
			req_r         <= 1'b0;
			we_r          <= 1'b0;
			burst_r       <= 1'b0;
			addr_r        <= 4'h0;
			wdata_r       <= 8'h00;
			ready_r       <= 1'b1;
			resp_valid_r  <= 1'b0;
			resp_rdata_r  <= 8'h00;
		end else begin
			req_r        <= 1'b0;
			resp_valid_r <= 1'b0;
			case (state_r)
				uart_bank_pkg::H_IDLE: begin
					if (cmd_valid && cmd_unlock) begin
						// Key first, so the unlock write is not gated
						addr_r        <= `OFS_LINE_CONTROL;
						wdata_r       <= `KEY_LINE_CONTROL;  // see RULE21
						we_r          <= 1'b1;
						burst_r       <= 1'b0;
						unlock_step_r <= 1'b0;
						ready_r       <= 1'b0;
						state_r       <= uart_bank_pkg::H_UNLOCK;
					end else if (cmd_valid) begin
						// Prescale M of 1 or 2 is left to the caller
						addr_r  <= cmd_addr;
						wdata_r <= cmd_wdata;
						we_r    <= cmd_write;
						burst_r <= cmd_burst;
						ready_r <= 1'b0;
						state_r <= uart_bank_pkg::H_ISSUE;
					end
				end
				uart_bank_pkg::H_UNLOCK: begin
					req_r   <= 1'b1;
					state_r <= uart_bank_pkg::H_WAIT;
				end
				uart_bank_pkg::H_ISSUE: begin
					req_r   <= 1'b1;
					state_r <= uart_bank_pkg::H_WAIT;
				end
				uart_bank_pkg::H_WAIT: begin
					if (bus.ack && we_r && addr_r == `OFS_LINE_CONTROL
						&& wdata_r == `KEY_LINE_CONTROL
						&& !unlock_step_r && !ready_r
						&& burst_r == 1'b0 && in_unlock_r) begin
						// Second unlock write while the key holds
						addr_r        <= `OFS_SPECIAL_UNLOCK;
						wdata_r       <= `KEY_SPECIAL_UNLOCK; // see RULE21
						unlock_step_r <= 1'b1;
						state_r       <= uart_bank_pkg::H_UNLOCK;
					end else if (bus.ack) begin
						resp_valid_r  <= 1'b1;
						resp_rdata_r  <= bus.rdata;
						unlock_step_r <= 1'b0;
						ready_r       <= 1'b1;
						state_r       <= uart_bank_pkg::H_IDLE;
					end
				end
				default: state_r <= uart_bank_pkg::H_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Unlock sequence tracking
	// ------------------------------------------------------------------
	// Latched when a command is taken, so plain key writes stay single
	always_ff @(posedge clk) begin
		if (srst) begin
			in_unlock_r <= 1'b0;
		end else if (state_r == uart_bank_pkg::H_IDLE) begin
			in_unlock_r <= cmd_valid && cmd_unlock;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign bus.req    = req_r;
	assign bus.we     = we_r;
	assign bus.burst  = burst_r;
	assign bus.addr   = addr_r;
	assign bus.wdata  = wdata_r;
	assign cmd_ready  = ready_r;
	assign resp_valid = resp_valid_r;
	assign resp_rdata = resp_rdata_r;

endmodule // special_bank_host

//--- test/special_bank_asserts.sv
// Protocol and register checks on the special bank link
`include "uart_bank_cfg.svh"

module special_bank_asserts (
	input wire logic                        clk,
	input wire logic                        srst,
	input wire logic                        req,
	input wire logic                        we,
	input wire logic                        burst,
	input wire logic [3:0]                  addr,
	input wire uart_bank_pkg::reg_byte_type wdata,
	input wire logic                        ack,
	input wire uart_bank_pkg::reg_byte_type rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	// ------------------------------------------------------------
	// Shadow of the key registers
	// ------------------------------------------------------------
	logic [7:0] lc_r; // Line control copy
	logic [7:0] un_r; // Unlock key copy
	logic [7:0] sf_r; // Special function copy
	// Burst beats are skipped: their offset is not on the wires
	wire wr_now = req && we && !burst;
	wire rd_now = req && !we && !burst;
	wire key_ok = (lc_r == `KEY_LINE_CONTROL);
	wire sf_ok  = key_ok && (un_r == `KEY_SPECIAL_UNLOCK);
	wire sp_ok  = key_ok && sf_r[`SFC_SPECIAL_ACCESS];
	wire sp_ofs = addr inside {4'h4, 4'h5, 4'h6, 4'h8, 4'h9};

	// Follow key writes exactly as the gating allows them
	always_ff @(posedge clk) begin
		if (srst) begin
			lc_r <= `RST_LINE_CONTROL;
			un_r <= `RST_SPECIAL_UNLOCK;
			sf_r <= `RST_SPECIAL_FUNC;
		end else if (wr_now) begin
			if (addr == `OFS_LINE_CONTROL)
				lc_r <= wdata;
			if (addr == `OFS_SPECIAL_UNLOCK && key_ok)
				un_r <= wdata;
			if (addr == `OFS_SPECIAL_FUNC && sf_ok)
				sf_r <= wdata;
		end
	end

	AST_ACK_FOLLOWS: assert property (req |=> ack)
		else $error("ack missing after request");
	AST_ACK_CAUSE: assert property (ack |-> $past(req))
		else $error("ack without request");
	AST_WRITE_ZERO: assert property (req && we |=> rdata == 8'h00)
		else $error("write answered with data");
	AST_RDATA_HOLD: assert property (!ack |-> $stable(rdata))
		else $error("read data moved without ack");
	AST_LC_READ: assert property (rd_now && addr == `OFS_LINE_CONTROL
		|=> rdata == lc_r)
		else $error("line control readback wrong");
	AST_SFC_GATE: assert property (rd_now && addr == `OFS_SPECIAL_FUNC
		&& !sf_ok |=> rdata == 8'h00)
		else $error("special function read while locked");
	AST_SFC_READ: assert property (rd_now && addr == `OFS_SPECIAL_FUNC
		&& sf_ok |=> rdata == sf_r)
		else $error("special function readback wrong");
	AST_SPECIAL_GATE: assert property (rd_now && sp_ofs && !sp_ok
		|=> rdata == 8'h00)
		else $error("special register read while gated");
	AST_CLEAR_SELF: assert property (rd_now && sp_ok
		&& addr == `OFS_INT_STATUS |=> !rdata[0])
		else $error("clear bit reads back set");
	AST_UNLOCK_READ: assert property (rd_now && key_ok
		&& addr == `OFS_SPECIAL_UNLOCK |=> rdata == un_r)
		else $error("unlock key readback wrong");

	// Main scenarios reached
	cover property (wr_now && addr == `OFS_SPECIAL_FUNC && sf_ok);
	cover property (req && burst);
	cover property (rd_now && sp_ok && addr == `OFS_INT_STATUS);
endmodule // special_bank_asserts

//--- test/test_uart_special_register_bank.sv
// Testbench joining host and device ends of the special bank link
module test_uart_special_register_bank;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;          // 200 MHz clock
	logic        srst = 1'b1;         // Sync reset
	logic        modem_bit7 = 1'b0;   // Baud exponent bit
	logic [15:0] baud_divisor = 16'h0000;
	logic [5:0]  fev = 6'h00;         // FIFO push/pop pulses
	logic [6:0]  int_events = 7'h00;  // Interrupt sources
	logic        cmd_valid = 1'b0;
	logic        cmd_write = 1'b0;
	logic        cmd_burst = 1'b0;
	logic        cmd_unlock = 1'b0;
	logic [3:0]  cmd_addr = 4'h0;
	logic [7:0]  cmd_wdata = 8'h00;
	wire         cmd_ready, resp_valid, baud_tick, loopback_en, burst_en;
	wire         auto_dsr_dtr_en, force_tx;
	wire  [7:0]  resp_rdata, tx_idle_time, extra_features;
	wire  [3:0]  prescale_m, prescale_n, sample_clock_value, txrx_enables;
	int          failures = 0;
	int          checks_done = 0;
	uart_bank_if link ();

	// Clock toggles every half period
	always #2.5 clk = ~clk;

	special_bank_host special_bank_host_i (.clk, .srst, .bus(link),
		.cmd_valid, .cmd_write, .cmd_burst, .cmd_unlock, .cmd_addr,
		.cmd_wdata, .cmd_ready, .resp_valid, .resp_rdata);
	special_bank_device special_bank_device_i (.clk, .srst, .bus(link),
		.modem_bit7, .baud_divisor, .rx_push(fev[5]),
		.rx_push_err(fev[4]), .rx_pop(fev[3]), .rx_pop_err(fev[2]),
		.tx_push(fev[1]), .tx_pop(fev[0]), .int_events, .baud_tick,
		.prescale_m, .prescale_n, .sample_clock_value, .loopback_en,
		.burst_en, .auto_dsr_dtr_en, .force_tx, .tx_idle_time,
		.txrx_enables, .extra_features);
	special_bank_asserts special_bank_asserts_i (.clk, .srst,
		.req(link.req), .we(link.we), .burst(link.burst),
		.addr(link.addr), .wdata(link.wdata), .ack(link.ack),
		.rdata(link.rdata));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One command; caller stands just after an edge with ready high
	task automatic cmd(input logic w, input logic b, input logic u,
		input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		cmd_write = w;
		cmd_burst = b;
		cmd_unlock = u;
		cmd_addr = a;
		cmd_wdata = d;
		cmd_valid = 1'b1;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		chk({15'h0000, cmd_ready}, 16'h0000);
		while (resp_valid !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(16'(n < 20), 16'h0001);
		chk({15'h0000, cmd_ready}, 16'h0001);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		cmd(1'b1, 1'b0, 1'b0, a, d);
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		cmd(1'b0, 1'b0, 1'b0, a, 8'h00);
		chk({8'h00, resp_rdata}, {8'h00, e});
	endtask

	task automatic pulse(input logic [5:0] v, input logic [6:0] ev);
		fev = v;
		int_events = ev;
		@(posedge clk);
		#1;
		fev = 6'h00;
		int_events = 7'h00;
		@(posedge clk);
		#1;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_gate;
		rd(4'h7, 8'h00);
		rd(4'h4, 8'h00);
		cmd(1'b1, 1'b0, 1'b1, 4'h0, 8'h00);
		rd(4'h3, 8'hBF);
		rd(4'hD, 8'h5A);
		rd(4'h4, 8'h00);
		rd(4'h7, 8'h00);
		wr(4'h7, 8'h04);
		rd(4'h4, 8'h10);
		rd(4'h9, 8'h06);
		rd(4'h5, 8'h00);
		rd(4'h6, 8'h00);
		rd(4'h8, 8'h00);
		rd(4'hF, 8'h00);
	endtask

	task automatic t_regs;
		wr(4'h4, 8'h2F);
		rd(4'h4, 8'h2F);
		chk({8'h00, prescale_m, prescale_n}, 16'h002F);
		wr(4'h9, 8'hA9);
		rd(4'h9, 8'hA9);
		chk({8'h00, sample_clock_value, txrx_enables}, 16'h00A9);
		wr(4'h8, 8'h5C);
		chk({8'h00, tx_idle_time}, 16'h005C);
	endtask

	// Period of baud_tick with divisor 3, M 2, N F, sample value A
	task automatic t_baud(input logic m7, input logic [15:0] exp);
		int n;
		baud_divisor = 16'h0003;
		modem_bit7 = m7;
		repeat (1200) @(posedge clk);
		#1;
		n = 0;
		while (baud_tick !== 1'b1 && n < 1200) begin
			@(posedge clk);
			#1;
			n++;
		end
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (baud_tick !== 1'b1 && n < 1200);
		chk(16'(n), exp);
	endtask

	task automatic t_sfc;
		logic [7:0] sel [4] = '{8'h01, 8'h02, 8'h08, 8'h10};
		for (int i = 0; i < 4; i++) begin
			wr(4'h7, 8'h04 | sel[i]);
			chk({12'h000, burst_en, loopback_en, auto_dsr_dtr_en,
				force_tx}, 16'h0001 << i);
		end
		wr(4'h7, 8'h04);
	endtask

	task automatic t_counts;
		pulse(6'b110000, 7'h00);
		pulse(6'b100010, 7'h00);
		pulse(6'b100010, 7'h00);
		pulse(6'b001000, 7'h00);
		rd(4'h5, 8'h02);
		wr(4'h5, 8'hFF);
		rd(4'h5, 8'h02);
		rd(4'h6, 8'h02);
		wr(4'h7, 8'h44);
		rd(4'h5, 8'h01);
		wr(4'h7, 8'h04);
	endtask

	task automatic t_status;
		pulse(6'h00, 7'h55);
		rd(4'hF, 8'hAA);
		pulse(6'h00, 7'h2A);
		rd(4'hF, 8'hFE);
		wr(4'hF, 8'h01);
		rd(4'hF, 8'h00);
		wr(4'hF, 8'h80);
		rd(4'hF, 8'h80);
		wr(4'h7, 8'h00);
		wr(4'hF, 8'hFF);
		chk({8'h00, extra_features}, 16'h00B7);
		rd(4'hF, 8'hB7);
		wr(4'h7, 8'h04);
	endtask

	// Burst beat after a read of 08 lands on 09
	task automatic t_burst;
		wr(4'h7, 8'h14);
		rd(4'h8, 8'h5C);
		cmd(1'b0, 1'b1, 1'b0, 4'h0, 8'h00);
		chk({8'h00, resp_rdata}, 16'h00A9);
		wr(4'h7, 8'h04);
	endtask

	task automatic wrap_up;
		$display("failures=%0d checks_done=%0d", failures, checks_done);
		if (failures == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog well beyond the expected run of a few thousand cycles
	initial begin
		#80000;
		failures++;
		wrap_up();
	end

	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		#1;
		srst = 1'b0;
		t_gate();
		t_regs();
		t_baud(1'b0, 16'd126);
		t_baud(1'b1, 16'd504);
		t_sfc();
		t_counts();
		t_status();
		t_burst();
		wrap_up();
	end
endmodule // test_uart_special_register_bank
